/* rst_pd_pkg.sv */
// Purpose: constants for the reset and power-down controller
// Assumes: 32-bit APB, word-aligned registers
// Notes:   offsets are byte addresses
package rst_pd_pkg;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_TIMER     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_CMD       = 8'h0C;
  localparam int          WAKE_EN_BIT    = 7;
  localparam int          DIV_LO_BIT     = 3;
  localparam logic [7:0]  CTRL_RESET     = 8'h80;
  localparam logic [7:0]  TIMER_RESET    = 8'h00;
  localparam logic [3:0]  WDT_OFF_CODE   = 4'hA;
  localparam logic [1:0]  DIV_SLOWEST    = 2'h0;
  localparam logic [7:0]  OP_HALT_OSC    = 8'h7F;
  localparam logic [7:0]  OP_CPU_SLEEP   = 8'h6F;
  localparam logic [15:0] RESET_VECTOR   = 16'h0100;
  localparam int          STAB_PERIODS   = 65536;
  localparam int          DIV_SEL_W      = 2;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_STAB  = 2'b01,
    ST_RUN   = 2'b11,
    ST_SLEEP = 2'b10
  } pd_state_t;
endpackage

/* reset_and_power_down_control.sv */
// Purpose: merge reset sources, run stabilization, handle halt-osc and sleep
// Assumes: clk_sys is the oscillator clock; osc gating is modelled by oscRun
// Notes:   registers reached over APB; cpu opcodes arrive as a strobe
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/10ps
module reset_and_power_down_control #(
  parameter int STAB_CYCLES = rst_pd_pkg::STAB_PERIODS,
  parameter int WDT_CYCLES  = 65536
) (
  input  wire logic                           clk_sys,
  input  wire logic                           nrst,
  input  wire logic                           clkEn,
  input  wire logic                           lvrSelect,
  input  wire logic                           ext_reset_in_n,
  input  wire logic                           lowVoltage,
  input  wire logic                           wdtRefresh,
  input  wire logic                           opStrobe,
  input  wire logic [7:0]                     opCode,
  input  wire logic                           ext_wake_irq0,
  input  wire logic                           ext_wake_irq1,
  input  wire logic                           irqPending,
  input  wire logic                           irqEnabled,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  output logic                                sysReset,
  output logic                                cpuClkEn,
  output logic                                oscRun,
  output logic                                periphClkEn,
  output logic                                vectorFetch,
  output logic [15:0]                         pcLoad,
  output logic                                irqService,
  output logic                                irqGlobalOff,
  output logic                                portsInput,
  output logic                                portDirHold,
  output logic [rst_pd_pkg::DIV_SEL_W-1:0]    divSel,
  output logic                                pinAsGpio
);
  import rst_pd_pkg::*;

  initial begin
    // the largest programmed shift is three, so the base count must survive it
    if ((STAB_CYCLES >> 3) < 2 || WDT_CYCLES < 2) begin
      $error("counts too small");
    end
  end

  localparam int CW = $clog2(STAB_CYCLES > WDT_CYCLES ? STAB_CYCLES : WDT_CYCLES) + 1;

  // two-stage synchronisers; first stage read only by the second
  logic       pinMeta;
  logic       pinSync;
  logic       lvMeta;
  logic       lvSync;
  logic [1:0] wakeMeta;
  logic [1:0] wakeSync;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pinMeta  <= 1'b0;
      pinSync  <= 1'b0;
      lvMeta   <= 1'b1;
      lvSync   <= 1'b1;
      wakeMeta <= 2'h0;
      wakeSync <= 2'h0;
    end else if (clkEn) begin
      pinMeta  <= ext_reset_in_n;
      pinSync  <= pinMeta;
      lvMeta   <= lowVoltage;
      lvSync   <= lvMeta;
      wakeMeta <= {ext_wake_irq1, ext_wake_irq0};
      wakeSync <= wakeMeta;
    end
  end

  // registers
  logic [7:0]      ctrlReg;
  logic [7:0]      timerReg;
  pd_state_t       state;
  logic            haltOsc;
  // stabilization entered by an interrupt wake: no reset, no vector fetch
  logic            wakeStab;
  logic            wdtFired;
  logic [CW-1:0]   stabCnt;
  logic [CW-1:0]   wdtCnt;

  // source merge
  wire pinReset   = !lvrSelect && !pinSync;
  wire lvReset    = lvrSelect && lvSync;
  wire anyReset   = pinReset || lvReset || wdtFired;
  wire wdtEnabled = timerReg[7:4] != WDT_OFF_CODE;
  wire wakeOk     = ctrlReg[WAKE_EN_BIT] && (|wakeSync);
  wire sleepWake  = irqPending && irqEnabled;

  // stabilization length: programmed value scales the base count
  wire [CW-1:0] stabLimit = CW'(STAB_CYCLES >> timerReg[1:0]);

  // apb decode
  wire acc     = psel && penable;
  wire wrCtrl  = acc && pwrite && paddr == ADDR_CTRL;
  wire wrTimer = acc && pwrite && paddr == ADDR_TIMER;
  wire wrCmd   = acc && pwrite && paddr == ADDR_CMD;
  wire mapped  = paddr == ADDR_CTRL || paddr == ADDR_TIMER ||
                 paddr == ADDR_STATUS || paddr == ADDR_CMD;
  wire opHalt  = state == ST_RUN && opStrobe && opCode == OP_HALT_OSC;
  wire opSleep = state == ST_RUN && opStrobe && opCode == OP_CPU_SLEEP;
  wire haltWake = haltOsc && wakeOk;

  // output terms; a reset raised in run must drop the cpu clock at once
  wire inReset   = anyReset || state == ST_RESET;
  wire stabDone  = state == ST_STAB && stabCnt >= stabLimit - 1'b1;
  wire runClk    = state == ST_RUN && !anyReset;
  wire periphOn  = !anyReset && (state == ST_RUN || state == ST_SLEEP && !haltOsc);
  wire resetHold = inReset || state == ST_STAB && !wakeStab;
  wire fetchNow  = stabDone && !wakeStab && !anyReset;

  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == ADDR_CTRL) begin
      next_prdata[7:0] = ctrlReg;
    end else if (paddr == ADDR_TIMER) begin
      next_prdata[7:0] = timerReg;
    end else if (paddr == ADDR_STATUS) begin
      next_prdata[3:0] = {wdtFired, haltOsc, state};
    end
  end

  // bus answers in the access cycle itself (zero wait)
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= next_prdata;
    end
  end

  // control registers default on any internal reset; kept on interrupt wake
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrlReg  <= CTRL_RESET;
      timerReg <= TIMER_RESET;
    end else if (clkEn) begin
      if (anyReset) begin
        ctrlReg  <= CTRL_RESET;
        timerReg <= TIMER_RESET;
      end else begin
        if (wrCtrl) begin
          ctrlReg <= pwdata[7:0];
        end
        if (wrTimer) begin
          timerReg <= pwdata[7:0];
        end
      end
    end
  end

  // watchdog; overflow fires a one-shot reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wdtCnt   <= '0;
      wdtFired <= 1'b0;
    end else if (clkEn) begin
      wdtFired <= 1'b0;
      if (wdtRefresh || !wdtEnabled || state != ST_RUN && state != ST_SLEEP) begin
        wdtCnt <= '0;
      end else if (wdtCnt == CW'(WDT_CYCLES - 1)) begin
        wdtCnt   <= '0;
        wdtFired <= 1'b1;
      end else begin
        wdtCnt <= wdtCnt + 1'b1;
      end
    end
  end

  // sequencer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state    <= ST_RESET;
      haltOsc  <= 1'b0;
      wakeStab <= 1'b0;
      stabCnt  <= '0;
    end else if (clkEn) begin
      if (anyReset) begin
        state    <= ST_RESET;
        haltOsc  <= 1'b0;
        wakeStab <= 1'b0;
        stabCnt  <= '0;
      end else begin
        unique case (state)
          ST_RESET: begin
            state   <= ST_STAB;
            stabCnt <= '0;
          end
          ST_STAB: begin
            // pin-release of halt shows up as anyReset, so only count here
            if (stabCnt >= stabLimit - 1'b1) begin
              state    <= ST_RUN;
              wakeStab <= 1'b0;
            end else begin
              stabCnt <= stabCnt + 1'b1;
            end
          end
          ST_RUN: begin
            if (opHalt || wrCmd && pwdata[7:0] == OP_HALT_OSC) begin
              haltOsc <= 1'b1;
              state   <= ST_SLEEP;
            end else if (opSleep || wrCmd && pwdata[7:0] == OP_CPU_SLEEP) begin
              state <= ST_SLEEP;
            end
          end
          ST_SLEEP: begin
            if (haltWake) begin
              haltOsc  <= 1'b0;
              wakeStab <= 1'b1;
              state    <= ST_STAB;
              stabCnt  <= '0;
            end else if (!haltOsc && sleepWake) begin
              state <= ST_RUN;
            end
          end
        endcase
      end
    end
  end

  // outputs, all registered
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sysReset     <= 1'b1;
      cpuClkEn     <= 1'b0;
      oscRun       <= 1'b1;
      periphClkEn  <= 1'b0;
      vectorFetch  <= 1'b0;
      pcLoad       <= RESET_VECTOR;
      irqService   <= 1'b0;
      irqGlobalOff <= 1'b1;
      portsInput   <= 1'b1;
      portDirHold  <= 1'b0;
      divSel       <= DIV_SLOWEST;
      pinAsGpio    <= 1'b0;
    end else if (clkEn) begin
      sysReset     <= resetHold;
      cpuClkEn     <= runClk;
      oscRun       <= !haltOsc;
      periphClkEn  <= periphOn;
      vectorFetch  <= fetchNow;
      pcLoad       <= RESET_VECTOR;
      irqService   <= state == ST_SLEEP && (haltWake || !haltOsc && sleepWake);
      irqGlobalOff <= inReset;
      portsInput   <= inReset;
      portDirHold  <= state == ST_SLEEP;
      divSel       <= ctrlReg[DIV_LO_BIT+DIV_SEL_W-1:DIV_LO_BIT];
      pinAsGpio    <= lvrSelect;
    end
  end
endmodule // reset_and_power_down_control

/* rst_pd_checker.sv */
// Purpose: port-level checks of the reset and power-down controller
// Assumes: one clock domain, nrst async active low
// Notes:   bound to every instance of the controller
`timescale 1ns/10ps
module rst_pd_checker (
  input wire logic                        clk_sys,
  input wire logic                        nrst,
  input wire logic                        lvrSelect,
  input wire logic                        ext_reset_in_n,
  input wire logic                        lowVoltage,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pready,
  input wire logic                        sysReset,
  input wire logic                        cpuClkEn,
  input wire logic                        oscRun,
  input wire logic                        periphClkEn,
  input wire logic                        vectorFetch,
  input wire logic                        portDirHold,
  input wire logic [15:0]                 pcLoad,
  input wire logic [rst_pd_pkg::DIV_SEL_W-1:0] divSel
);
  import rst_pd_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_VECTOR: assert property (pcLoad == RESET_VECTOR)
    else $error("pc load value wrong");
  // six cycles covers the two-stage sync plus the sysReset output register
  AST_PIN_RST: assert property ((!ext_reset_in_n && !lvrSelect) [*6] |-> sysReset)
    else $error("pin low gave no reset");
  AST_LVR_RST: assert property ((lowVoltage && lvrSelect) [*6] |-> sysReset)
    else $error("low supply gave no reset");
  AST_RUN_GATE: assert property (cpuClkEn |-> !sysReset && oscRun && periphClkEn)
    else $error("cpu clock on during reset or halt");
  AST_HALT_OFF: assert property (!oscRun |-> !cpuClkEn && !periphClkEn && portDirHold)
    else $error("clocks running in halt");
  AST_SLEEP_HOLD: assert property (oscRun && periphClkEn && !cpuClkEn |-> portDirHold)
    else $error("port direction not held in sleep");
  AST_FETCH: assert property ($rose(vectorFetch) |-> ##[0:2] cpuClkEn)
    else $error("fetch without cpu clock");
  AST_DIV_RST: assert property ($rose(sysReset) |-> ##[0:2] divSel == DIV_SLOWEST)
    else $error("divider not slowest after reset");
  AST_APB_READY: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
    else $error("no zero-wait ready");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
endmodule // rst_pd_checker

bind reset_and_power_down_control rst_pd_checker chk (.*);

/* rst_pd_partner.sv */
// Purpose: cpu core, reset circuit and wake source facing the controller
// Assumes: driven by task calls from the bench
// Notes:   all changes land just after a rising edge
`timescale 1ns/10ps
module rst_pd_partner (
  input  wire logic       clk_sys,
  output logic            extRstN,
  output logic            opStb,
  output logic [7:0]      opCode,
  output logic            wake1
);
  initial {extRstN, opStb, opCode, wake1} = {1'b1, 1'b0, 8'h00, 1'b0};
  task automatic pinLow(input int n);
    extRstN <= 1'b0;
    repeat (n) @(posedge clk_sys);
    extRstN <= 1'b1;
  endtask
  // converter assumed off before any power-down opcode
  task automatic issue(input logic [7:0] c);
    opCode <= c;
    opStb <= 1'b1;
    @(posedge clk_sys);
    opStb <= 1'b0;
  endtask
  task automatic wake;
    wake1 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wake1 <= 1'b0;
  endtask
endmodule // rst_pd_partner

/* reset_and_power_down_control_test.sv */
// Purpose: self-checking bench for the reset and power-down controller
// Assumes: short stabilization and watchdog counts
// Notes:   opcodes, pin and wake come from the partner model
`timescale 1ns/10ps
module reset_and_power_down_control_test;
  import rst_pd_pkg::*;
  localparam int STAB = 16;
  logic clk_sys = 1'b0, nrst = 1'b0, lvrSelect = 1'b0, lowVoltage = 1'b0;
  logic wdtRefresh = 1'b0, refreshOn = 1'b1, irqPending = 1'b0, irqEnabled = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, sysReset, cpuClkEn, oscRun, periphClkEn, vectorFetch;
  logic irqService, irqGlobalOff, portsInput, portDirHold, pinAsGpio;
  logic extRstN, opStb, wake1;
  logic [7:0] opCode;
  logic [15:0] pcLoad;
  logic [1:0] divSel;
  int n_fail = 0, comparisons = 0, n, svc = 0, s0, rs = 0, r0;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) wdtRefresh <= refreshOn && !wdtRefresh;
  always @(posedge clk_sys) if (irqService === 1'b1) svc++;
  always @(posedge clk_sys) if (sysReset === 1'b1) rs++;
  rst_pd_partner cpu (.*);
  reset_and_power_down_control #(.STAB_CYCLES(STAB), .WDT_CYCLES(64)) dut (.*,
    .clkEn(1'b1), .ext_reset_in_n(extRstN), .opStrobe(opStb),
    .ext_wake_irq0(1'b0), .ext_wake_irq1(wake1));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bad(input string m);
    n_fail++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) bad($sformatf("got %h want %h", g, x));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      bad("apb hang");
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never re-drives psel in this time step
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk32(q, x);
  endtask
  // bounded wait for a level, n gives the edges spent less one (the edge that saw the level)
  task automatic waitHi(ref logic s, output int n);
    for (n = 0; n < 400; n++) begin
      @(posedge clk_sys);
      if (s === 1'b1) break;
    end
    if (n == 400) begin
      bad("wait hang");
      final_report();
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    waitHi(cpuClkEn, n);
    chk32(32'(n >= STAB), 32'h1);
    chk32({16'h0, pcLoad}, 32'(RESET_VECTOR));
    rd(ADDR_CTRL, 32'(CTRL_RESET));
    rd(ADDR_TIMER, 32'(TIMER_RESET));
    rd(ADDR_STATUS, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk32({31'h0, e}, 32'h1);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CTRL, 32'h80 | (i << DIV_LO_BIT));
      @(posedge clk_sys);
      chk32({30'h0, divSel}, 32'(i));
    end
    cpu.issue(OP_CPU_SLEEP);
    repeat (2) @(posedge clk_sys);
    chk32({cpuClkEn, periphClkEn, portDirHold}, 32'h3);
    irqPending <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk32({31'h0, cpuClkEn}, 32'h0);
    s0 = svc;
    irqEnabled <= 1'b1;
    waitHi(cpuClkEn, n);
    irqPending <= 1'b0;
    irqEnabled <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk32({30'h0, divSel}, 32'h3);
    chk32(32'(svc > s0), 32'h1);
    $display("sleep test done");
    apb(1'b1, ADDR_TIMER, 32'h0);
    cpu.issue(OP_HALT_OSC);
    irqPending <= 1'b1;
    irqEnabled <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk32({oscRun, cpuClkEn}, 32'h0);
    irqPending <= 1'b0;
    irqEnabled <= 1'b0;
    s0 = svc;
    r0 = rs;
    cpu.wake();
    waitHi(cpuClkEn, n);
    chk32(32'(n + 3 >= STAB), 32'h1);
    repeat (2) @(posedge clk_sys);
    chk32(32'(svc > s0), 32'h1);
    chk32(32'(rs == r0), 32'h1);
    rd(ADDR_CTRL, 32'h98);
    cpu.issue(OP_HALT_OSC);
    cpu.pinLow(STAB);
    waitHi(cpuClkEn, n);
    rd(ADDR_CTRL, 32'(CTRL_RESET));
    chk32({30'h0, divSel}, 32'(DIV_SLOWEST));
    $display("halt test done");
    refreshOn <= 1'b0;
    waitHi(sysReset, n);
    chk32(32'(n <= 72), 32'h1);
    refreshOn <= 1'b1;
    waitHi(cpuClkEn, n);
    apb(1'b1, ADDR_TIMER, 32'hA0);
    refreshOn <= 1'b0;
    repeat (150) @(posedge clk_sys);
    chk32({31'h0, sysReset}, 32'h0);
    refreshOn <= 1'b1;
    $display("watchdog test done");
    lvrSelect <= 1'b1;
    lowVoltage <= 1'b1;
    repeat (48) @(posedge clk_sys);
    chk32({sysReset, pinAsGpio, irqGlobalOff, portsInput}, 32'hF);
    lowVoltage <= 1'b0;
    waitHi(cpuClkEn, n);
    cpu.pinLow(8);
    chk32({31'h0, sysReset}, 32'h0);
    $display("low voltage test done");
    final_report();
  end
endmodule // reset_and_power_down_control_test
